/* File: hdl/scpmc_device.sv */
// Serial command decoder with analog monitor select register
// How it works
// [R01] Type 00, bit7 low: status plus register
// [R02] Type 00, bit7 high: status plus ID/pins
// [R03] Type 01 write; returns fixed, extended status
// [R04] Type 11 flag read, bit7 picks sub-address
// [R05] Flag read: status high byte, flags low
// [R06] Parity covers all bits except bit 8
// [R07] Host: bit8 is 1 when count even
// [R08] Parity checked only when misc bit6 set
// [R09] Host sends write bit8 zero without parity
// [R10] Monitor bits 7-5 pick source, 000 off
// [R11] Source codes 001 through 111 mapped
// [R12] Bit 4 connects internal load resistor
// [R13] Bit 3 picks gain or attenuation; code uses it only for sources 100 and 101
// [R14] Monitor clears on reset, supply off, non-Normal
// [R15] Monitor access only with supply on
// [R16] Bad parity write is discarded
// [R17] Monitor bits 2-0 read as zero
`timescale 1ns/1ps
`default_nettype none
`include "scpmc_cfg.svh"
module scpmc_device (
    input  wire logic                core_clk_in,
    input  wire logic                rst_in,
    scpmc_if.device                  link,
    input  wire scpmc_pkg::scpmc_byte_t fixed_status_in,
    input  wire scpmc_pkg::scpmc_byte_t ext_status_in,
    input  wire scpmc_pkg::scpmc_byte_t device_info_in,
    input  wire scpmc_pkg::scpmc_byte_t flags_low_in,
    input  wire scpmc_pkg::scpmc_byte_t flags_high_in,
    input  wire logic                can_supply_regulator_on_in,
    input  wire logic                normal_mode_in,
    output logic [2:0]               monitor_source_out,
    output logic                     analog_monitor_output_en_out,
    output logic                     internal_load_resistor_en_out,
    output logic                     io_attenuate_out,
    output logic                     parity_error_out,
    output logic [4:0]               wr_addr_out,
    output scpmc_pkg::scpmc_byte_t   wr_data_out,
    output logic                     wr_strobe_out
);
    import scpmc_pkg::*;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] sclk_r, cs_r, mosi_r;
    logic       sclk_q_r;
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sclk_r   <= 3'h0;
            cs_r     <= 3'h7;
            mosi_r   <= 3'h0;
            sclk_q_r <= 1'b0;
        end else begin
            sclk_r   <= {sclk_r[1:0], link.sclk};
            cs_r     <= {cs_r[1:0], link.cs_n};
            mosi_r   <= {mosi_r[1:0], link.mosi};
            if (sclk_r[2] == sclk_r[1]) begin
                sclk_q_r <= sclk_r[2];
            end
        end
    end
    logic cs_prev_r;
    wire sclk_st  = (sclk_r[2] == sclk_r[1]) ? sclk_r[2] : sclk_q_r;
    wire cs_act   = (cs_r[2] == cs_r[1]) && !cs_r[2];
    // Idle only once both late stages agree high
    wire cs_idle  = (cs_r[2] == cs_r[1]) && cs_r[2];
    wire cs_rise  = cs_idle && !cs_prev_r;
    wire rise     = sclk_st && !sclk_q_r && cs_act;
    wire fall     = !sclk_st && sclk_q_r && cs_act;

    // ----------------------------------------
    // Shift registers
    // ----------------------------------------
    scpmc_frame_t rx_r, tx_r;
    logic [4:0]   cnt_r;
    logic [7:0]   mon_r, misc_r;
    logic         perr_r;

    wire [1:0] cmd    = rx_r[`SCPMC_CMD_HI:`SCPMC_CMD_LO];
    wire [4:0] addr   = rx_r[`SCPMC_ADDR_HI:`SCPMC_ADDR_LO];
    wire [7:0] data   = rx_r[7:0];
    wire       sub    = rx_r[`SCPMC_SUB_BIT];
    wire       par_ok = ^rx_r;  // [R06] odd total incl bit 8 is correct
    wire       par_en = misc_r[`SCPMC_PAR_EN_BIT];  // [R08]
    wire       frame_done = cs_rise && (cnt_r == `SCPMC_CNT_LAST);
    wire       is_wr  = frame_done && (cmd == `SCPMC_CMD_WRITE);
    wire       wr_ok  = is_wr && (!par_en || par_ok);  // [R16]
    wire       mon_gate = can_supply_regulator_on_in && normal_mode_in;
    wire       mon_hit  = frame_done && (addr == `SCPMC_ADDR_MON)
                          && (cmd == `SCPMC_CMD_READ || cmd == `SCPMC_CMD_WRITE);

    // Early header decode when first byte is in
    wire [15:0] hdr    = {rx_r[14:0], mosi_r[2]};
    // First byte sits in the low half of the shifter
    wire [1:0]  h_cmd  = rx_r[`SCPMC_CMD_HI-`SCPMC_HDR_SHIFT:`SCPMC_CMD_LO-`SCPMC_HDR_SHIFT];
    wire [4:0]  h_addr = rx_r[`SCPMC_ADDR_HI-`SCPMC_HDR_SHIFT:`SCPMC_ADDR_LO-`SCPMC_HDR_SHIFT];
    wire        h_sub  = mosi_r[2];
    wire [7:0]  mon_rd = mon_gate ? (mon_r & `SCPMC_MON_KEEP) : `SCPMC_MON_RESET;  // [R15][R17]
    wire [7:0]  reg_rd = (h_addr == `SCPMC_ADDR_MON)  ? mon_rd :
                         (h_addr == `SCPMC_ADDR_MISC) ? misc_r : 8'h00;
    wire [7:0]  low_byte =
        (h_cmd == `SCPMC_CMD_WRITE) ? ext_status_in :                     // [R03]
        (h_cmd == `SCPMC_CMD_FLAGS) ? (h_sub ? flags_high_in : flags_low_in) :  // [R04][R05]
        (h_cmd == `SCPMC_CMD_READ)  ? (h_sub ? device_info_in : reg_rd) :  // [R01][R02]
        8'h00;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            rx_r      <= 16'h0000;
            tx_r      <= 16'h0000;
            cnt_r     <= 5'h00;
            cs_prev_r <= 1'b1;
        end else begin
            cs_prev_r <= cs_r[2];
            // Count survives the deselect settling window
            if (cs_idle) begin
                cnt_r <= 5'h00;
                tx_r  <= {fixed_status_in, 8'h00};
            end else if (rise) begin
                rx_r  <= hdr;
                cnt_r <= cnt_r + 5'h01;
            end else if (fall) begin
                tx_r  <= (cnt_r == `SCPMC_CNT_BYTE) ? {low_byte, 8'h00} : {tx_r[14:0], 1'b0};
            end
        end
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            mon_r         <= `SCPMC_MON_RESET;  // [R14]
            misc_r        <= 8'h00;
            perr_r        <= 1'b0;
            wr_addr_out   <= 5'h00;
            wr_data_out   <= 8'h00;
            wr_strobe_out <= 1'b0;
        end else begin
            wr_strobe_out <= wr_ok;
            if (wr_ok) begin
                wr_addr_out <= addr;
                wr_data_out <= data;
            end
            if (is_wr && !wr_ok) begin
                perr_r <= 1'b1;
            end else if (wr_ok) begin
                perr_r <= 1'b0;
            end
            if (wr_ok && addr == `SCPMC_ADDR_MISC) begin
                misc_r <= data;
            end
            if (!mon_gate) begin
                mon_r <= `SCPMC_MON_RESET;  // [R14][R15]
            end else if (wr_ok && mon_hit) begin
                mon_r <= data & `SCPMC_MON_KEEP;  // [R17]
            end
        end
    end

    // ----------------------------------------
    // Monitor decode and outputs
    // ----------------------------------------
    wire [2:0] sel    = mon_r[`SCPMC_SEL_HI:`SCPMC_SEL_LO];  // [R11]
    wire       io_sel = (sel == `SCPMC_SEL_IO0) || (sel == `SCPMC_SEL_IO1);
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            monitor_source_out            <= 3'h0;
            analog_monitor_output_en_out  <= 1'b0;
            internal_load_resistor_en_out <= 1'b0;
            io_attenuate_out              <= 1'b0;
            parity_error_out              <= 1'b0;
            link.miso                     <= 1'b0;
            link.miso_oe                  <= 1'b0;
        end else begin
            monitor_source_out            <= sel;
            analog_monitor_output_en_out  <= (sel != 3'h0);  // [R10]
            internal_load_resistor_en_out <= mon_r[`SCPMC_LOAD_BIT];  // [R12]
            io_attenuate_out              <= io_sel && mon_r[`SCPMC_ATT_BIT];  // [R13]
            parity_error_out              <= perr_r;
            link.miso                     <= tx_r[15];
            link.miso_oe                  <= cs_act;
        end
    end
endmodule : scpmc_device
`default_nettype wire

/* File: inc/scpmc_cfg.svh */
// Frame layout, command codes and monitor register constants
`ifndef SCPMC_CFG_SVH
`define SCPMC_CFG_SVH
`define SCPMC_FRAME_W      16
`define SCPMC_CMD_HI       15
`define SCPMC_CMD_LO       14
`define SCPMC_ADDR_HI      13
`define SCPMC_ADDR_LO      9
`define SCPMC_PAR_BIT      8
`define SCPMC_SUB_BIT      7
`define SCPMC_CMD_READ     2'h0
`define SCPMC_CMD_WRITE    2'h1
`define SCPMC_CMD_FLAGS    2'h3
`define SCPMC_ADDR_MON     5'h00
`define SCPMC_ADDR_MISC    5'h08
`define SCPMC_PAR_EN_BIT   6
`define SCPMC_MON_RESET    8'h00
`define SCPMC_MON_KEEP     8'hF8
`define SCPMC_SEL_HI       7
`define SCPMC_SEL_LO       5
`define SCPMC_LOAD_BIT     4
`define SCPMC_ATT_BIT      3
`define SCPMC_SEL_IO0      3'h4
`define SCPMC_SEL_IO1      3'h5
`define SCPMC_HALF_DIV     8'h08
`define SCPMC_CNT_LAST     5'h10
`define SCPMC_CNT_BYTE     5'h08
`define SCPMC_HDR_SHIFT    8
// Host register port offsets
`define SCPMC_HREG_CMD     4'h0
`define SCPMC_HREG_START   4'h1
`define SCPMC_HREG_RX      4'h2
`define SCPMC_HREG_STAT    4'h3
`define SCPMC_HREG_MASK    4'h4
`endif

/* File: inc/scpmc_pkg.sv */
// Types shared by both ends
package scpmc_pkg;
    typedef logic [15:0] scpmc_frame_t;
    typedef logic [7:0]  scpmc_byte_t;
endpackage : scpmc_pkg

/* File: inc/scpmc_if.sv */
// Four-wire serial link between host and device
`timescale 1ns/1ps
`default_nettype none
interface scpmc_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    modport host   (output sclk, output cs_n, output mosi, input miso);
    modport device (input sclk, input cs_n, input mosi, output miso, output miso_oe);
endinterface : scpmc_if
`default_nettype wire

/* File: hdl/scpmc_host.sv */
// Host end: frames commands from a register port onto the link
`timescale 1ns/1ps
`default_nettype none
`include "scpmc_cfg.svh"
module scpmc_host (
    input  wire logic                 core_clk_in,
    input  wire logic                 rst_in,
    scpmc_if.host                     link,
    input  wire logic [3:0]           addr_in,
    input  wire logic [15:0]          wdata_in,
    input  wire logic                 wr_in,
    input  wire logic                 rd_in,
    input  wire logic                 parity_en_in,
    output logic [15:0]               rdata_out,
    output logic                      irq_out
);
    import scpmc_pkg::*;

    typedef enum logic [1:0] {
        SCPMC_IDLE  = 2'b00,
        SCPMC_SHIFT = 2'b01,
        SCPMC_DONE  = 2'b10
    } scpmc_state_t;

    scpmc_state_t state_r;
    scpmc_frame_t cmd_r, tx_r, rx_r;
    logic [7:0]   div_r;
    logic [4:0]   bit_r;
    logic [2:0]   miso_r;
    logic         stat_r, mask_r;

    wire wr_cmd   = wr_in && addr_in == `SCPMC_HREG_CMD;
    wire wr_start = wr_in && addr_in == `SCPMC_HREG_START;
    wire wr_mask  = wr_in && addr_in == `SCPMC_HREG_MASK;
    wire rd_stat  = rd_in && addr_in == `SCPMC_HREG_STAT;
    wire is_wr    = cmd_r[15:14] == `SCPMC_CMD_WRITE;
    wire even1    = ~(^{cmd_r[15:9], cmd_r[7:0]});
    // Bit 8 fixed by command type and parity mode
    wire par_bit  = (cmd_r[15:14] == `SCPMC_CMD_READ || cmd_r[15:14] == `SCPMC_CMD_FLAGS)
                    ? 1'b1 : (parity_en_in && is_wr) ? even1 : 1'b0;  // [R06][R07][R09]
    wire half     = div_r == `SCPMC_HALF_DIV - 8'h01;
    wire done_ev  = state_r == SCPMC_DONE;

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            state_r   <= SCPMC_IDLE;
            cmd_r     <= 16'h0000;
            tx_r      <= 16'h0000;
            rx_r      <= 16'h0000;
            div_r     <= 8'h00;
            bit_r     <= 5'h00;
            miso_r    <= 3'h0;
            link.sclk <= 1'b0;
            link.cs_n <= 1'b1;
            link.mosi <= 1'b0;
        end else begin
            miso_r <= {miso_r[1:0], link.miso};
            if (wr_cmd && state_r == SCPMC_IDLE) begin
                cmd_r <= wdata_in;
            end
            unique case (state_r)
                SCPMC_IDLE: begin
                    if (wr_start) begin
                        tx_r      <= {cmd_r[15:9], par_bit, cmd_r[7:0]};
                        link.mosi <= cmd_r[15];
                        link.cs_n <= 1'b0;
                        div_r     <= 8'h00;
                        bit_r     <= 5'h00;
                        state_r   <= SCPMC_SHIFT;
                    end
                end
                SCPMC_SHIFT: begin
                    div_r <= half ? 8'h00 : div_r + 8'h01;
                    if (half && !link.sclk) begin
                        link.sclk <= 1'b1;
                        bit_r     <= bit_r + 5'h01;
                    end else if (half) begin
                        link.sclk <= 1'b0;
                        // Sample late: synchronised answer lags the rising edge
                        rx_r      <= {rx_r[14:0], miso_r[2]};
                        tx_r      <= {tx_r[14:0], 1'b0};
                        link.mosi <= tx_r[14];
                        if (bit_r == `SCPMC_CNT_LAST) begin
                            state_r <= SCPMC_DONE;
                        end
                    end
                end
                SCPMC_DONE: begin
                    link.cs_n <= 1'b1;
                    state_r   <= SCPMC_IDLE;
                end
                default: state_r <= SCPMC_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            stat_r    <= 1'b0;
            mask_r    <= 1'b0;
            irq_out   <= 1'b0;
            rdata_out <= 16'h0000;
        end else begin
            if (wr_mask) begin
                mask_r <= wdata_in[0];
            end
            if (done_ev) begin
                stat_r <= 1'b1;
            end else if (rd_stat) begin
                stat_r <= 1'b0;
            end
            irq_out <= stat_r && mask_r && !(rd_stat && !done_ev);
            unique case (addr_in)
                `SCPMC_HREG_CMD:  rdata_out <= cmd_r;
                `SCPMC_HREG_RX:   rdata_out <= rx_r;
                `SCPMC_HREG_STAT: rdata_out <= {14'h0000, state_r != SCPMC_IDLE, stat_r};
                `SCPMC_HREG_MASK: rdata_out <= {15'h0000, mask_r};
                default:          rdata_out <= 16'h0000;
            endcase
        end
    end
endmodule : scpmc_host
`default_nettype wire

/* File: sim/scpmc_assertions.sv */
// Link framing and monitor register checks
`timescale 1ns/1ps
`default_nettype none
module scpmc_assertions (
    input wire logic       core_clk_in,
    input wire logic       rst_in,
    input wire logic       sclk,
    input wire logic       cs_n,
    input wire logic       miso_oe,
    input wire logic       can_supply_regulator_on_in,
    input wire logic       normal_mode_in,
    input wire logic [2:0] monitor_source_out,
    input wire logic       analog_monitor_output_en_out,
    input wire logic       internal_load_resistor_en_out,
    input wire logic       io_attenuate_out,
    input wire logic       parity_error_out,
    input wire logic       wr_strobe_out
);
    // ----------------------------------------
    // Serial clock edge counter per frame
    // ----------------------------------------
    logic       sclk_d_r;
    logic       sclk_rise;
    logic [5:0] edge_cnt_r;
    logic [5:0] edge_cnt_nxt;
    assign sclk_rise    = sclk && !sclk_d_r;
    assign edge_cnt_nxt = cs_n ? 6'h00 : edge_cnt_r + {5'h00, sclk_rise};
    always_ff @(posedge core_clk_in) begin
        sclk_d_r   <= rst_in ? 1'b0 : sclk;
        edge_cnt_r <= rst_in ? 6'h00 : edge_cnt_nxt;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    frame_edges_a: assert property ($rose(cs_n) |-> edge_cnt_r == 6'h10)
        else $error("frame did not carry 16 clock edges");
    sclk_idle_a: assert property (cs_n && $past(cs_n) && !$past(rst_in, 2) |-> $stable(sclk))
        else $error("serial clock moved outside a frame");
    miso_release_a: assert property (cs_n [*8] |-> !miso_oe)
        else $error("data out driven while deselected");
    strobe_pulse_a: assert property (wr_strobe_out |=> !wr_strobe_out)
        else $error("write strobe longer than one cycle");
    strobe_idle_a: assert property (wr_strobe_out |-> cs_n)
        else $error("write taken before frame end");
    supply_clear_a: assert property (!can_supply_regulator_on_in [*4] |->
        monitor_source_out == 3'h0 && !internal_load_resistor_en_out && !io_attenuate_out)
        else $error("monitor not cleared with supply off");
    mode_clear_a: assert property (!normal_mode_in [*4] |->
        monitor_source_out == 3'h0 && !internal_load_resistor_en_out && !io_attenuate_out)
        else $error("monitor not cleared outside normal mode");
    source_off_a: assert property (monitor_source_out == 3'h0 [*3] |-> !analog_monitor_output_en_out)
        else $error("monitor output driven with no source");
    source_on_a: assert property (monitor_source_out != 3'h0 [*3] |-> analog_monitor_output_en_out)
        else $error("monitor output idle with a source");
    parity_drop_a: assert property ($rose(parity_error_out) |->
        !wr_strobe_out && !$past(wr_strobe_out))
        else $error("bad parity write was taken");
endmodule : scpmc_assertions
`default_nettype wire

/* File: sim/spi_command_parity_mux_ctrl_tb_top.sv */
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps
`default_nettype none
`include "scpmc_cfg.svh"
module spi_command_parity_mux_ctrl_tb_top;
    import scpmc_pkg::*;
    localparam scpmc_byte_t FS = 8'hA5, EXT = 8'h3C, INFO = 8'h96, FL = 8'h5A, FH = 8'hC3;
    logic        core_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0, rd = 1'b0, par_en = 1'b0, can_on = 1'b1, normal = 1'b1;
    logic [15:0] rdata, rx;
    logic        irq, perr, wstb, mon_en, load_en, att;
    logic [2:0]  src;
    logic [4:0]  waddr;
    logic [7:0]  wdat;
    int          fail_count = 0, total_checks = 0, cyc = 0;
    scpmc_if u_scpmc_if ();
    always #4 core_clk_in = ~core_clk_in;
    scpmc_host u_scpmc_host (.core_clk_in(core_clk_in), .rst_in(rst_in), .link(u_scpmc_if.host),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .parity_en_in(par_en),
        .rdata_out(rdata), .irq_out(irq));
    scpmc_device u_scpmc_device (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .link(u_scpmc_if.device), .fixed_status_in(FS), .ext_status_in(EXT),
        .device_info_in(INFO), .flags_low_in(FL), .flags_high_in(FH),
        .can_supply_regulator_on_in(can_on), .normal_mode_in(normal),
        .monitor_source_out(src), .analog_monitor_output_en_out(mon_en),
        .internal_load_resistor_en_out(load_en), .io_attenuate_out(att),
        .parity_error_out(perr), .wr_addr_out(waddr), .wr_data_out(wdat), .wr_strobe_out(wstb));
    scpmc_assertions u_scpmc_assertions (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .sclk(u_scpmc_if.sclk), .cs_n(u_scpmc_if.cs_n), .miso_oe(u_scpmc_if.miso_oe),
        .can_supply_regulator_on_in(can_on), .normal_mode_in(normal),
        .monitor_source_out(src), .analog_monitor_output_en_out(mon_en),
        .internal_load_resistor_en_out(load_en), .io_attenuate_out(att),
        .parity_error_out(perr), .wr_strobe_out(wstb));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk_in);
        wr    <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge core_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk_in);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg
    task automatic send(input logic [15:0] f);
        wr_reg(`SCPMC_HREG_CMD, f);
        wr_reg(`SCPMC_HREG_START, 16'h0001);
    endtask : send
    task automatic xfer(input logic [15:0] f);
        logic [15:0] s;
        s = 16'h0000;
        send(f);
        for (int i = 0; i < 300 && !s[0]; i++) rd_reg(`SCPMC_HREG_STAT, s);
        chk(s & 16'h0001, 16'h0001);
        rd_reg(`SCPMC_HREG_RX, rx);
        repeat (4) @(posedge core_clk_in);
    endtask : xfer
    function automatic logic [15:0] fr(input logic [1:0] c, input logic [4:0] a,
                                       input logic p, input logic [7:0] d);
        return {c, a, p, d};
    endfunction : fr
    function automatic logic [15:0] mon();
        return {9'h000, src, mon_en, load_en, att, perr};
    endfunction : mon
    always @(posedge core_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(posedge core_clk_in);
        xfer(fr(2'h1, 5'h00, 1'b0, 8'hBF));
        chk(rx, {FS, EXT});
        chk({3'h0, waddr, wdat}, {3'h0, 5'h00, 8'hBF});
        chk(mon(), {9'h000, 3'h5, 4'hE});
        xfer(fr(2'h0, 5'h00, 1'b1, 8'h00));
        chk(rx, {FS, 8'hB8});
        xfer(fr(2'h0, 5'h00, 1'b1, 8'h80));
        chk(rx, {FS, INFO});
        for (int s = 0; s < 2; s++) begin
            xfer(fr(2'h3, 5'h10, 1'b1, {s[0], 7'h00}));
            chk(rx, {FS, s[0] ? FH : FL});
        end
        for (int c = 0; c < 8; c++) begin
            xfer(fr(2'h1, 5'h00, 1'b0, {c[2:0], 5'h08}));
            chk(mon(), {9'h000, c[2:0], c != 0, 1'b0, c == 4 || c == 5, 1'b0});
        end
        can_on <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        chk(mon(), 16'h0000);
        xfer(fr(2'h1, 5'h00, 1'b0, 8'hE0));
        chk(mon(), 16'h0000);
        can_on <= 1'b1;
        xfer(fr(2'h0, 5'h00, 1'b1, 8'h00));
        chk(rx, {FS, 8'h00});
        xfer(fr(2'h1, 5'h00, 1'b0, 8'hE0));
        chk(mon(), {9'h000, 3'h7, 4'h8});
        normal <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        chk(mon(), 16'h0000);
        normal <= 1'b1;
        xfer(fr(2'h1, `SCPMC_ADDR_MISC, 1'b0, 8'h40));
        chk({3'h0, waddr, wdat}, {3'h0, `SCPMC_ADDR_MISC, 8'h40});
        xfer(fr(2'h1, 5'h00, 1'b0, 8'h60));
        chk(mon(), {9'h000, 3'h3, 4'h8});
        xfer(fr(2'h1, 5'h00, 1'b0, 8'h40));
        chk(mon(), {9'h000, 3'h3, 4'h9});
        par_en <= 1'b1;
        xfer(fr(2'h1, 5'h00, 1'b0, 8'h40));
        chk(mon(), {9'h000, 3'h2, 4'h8});
        par_en <= 1'b0;
        // Completion with interrupt disabled, then enabled
        wr_reg(`SCPMC_HREG_MASK, 16'h0000);
        send(fr(2'h0, 5'h00, 1'b1, 8'h00));
        for (int i = 0; i < 600 && u_scpmc_if.cs_n; i++) @(posedge core_clk_in);
        for (int i = 0; i < 600 && !u_scpmc_if.cs_n; i++) @(posedge core_clk_in);
        repeat (8) @(posedge core_clk_in);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(`SCPMC_HREG_MASK, 16'h0001);
        rd_reg(`SCPMC_HREG_MASK, rx);
        chk(rx, 16'h0001);
        repeat (3) @(posedge core_clk_in);
        chk({15'h0000, irq}, 16'h0001);
        rd_reg(`SCPMC_HREG_STAT, rx);
        chk(rx & 16'h0001, 16'h0001);
        repeat (3) @(posedge core_clk_in);
        chk({15'h0000, irq}, 16'h0000);
        stop_test();
    end
endmodule : spi_command_parity_mux_ctrl_tb_top
`default_nettype wire
